// ### hw/eeprom_page_host.sv
// Host controller that page-loads an erasable memory and polls for write completion.
//
// Behaviour
// - Bank bits are held from the page's first byte to page-load end.
// - Write strobe is held low at least the strobe low width.
// - Next byte waits at least 0.2 us; page ends after window silence.
// - A stalled source stretches the load by holding the strobe low.
// - First poll waits poll_wait_time after the final byte.
// - The poll wait is at most 1 ms.
// - Poll reads use ordinary read strobe and access timing.
`timescale 1ns/1ns
`include "eeprom_host_regs.svh"
module eeprom_page_host
  import eeprom_host_pkg::*;
#(
  parameter int POLL_WAIT_CYCLES = `POLL_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Write request stream
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire wr_req_s     req,
  // Status
  input  wire logic        power_good,
  output logic             busy,
  output logic             done_pulse,
  output logic             page_error,
  // Memory pins
  output mem_pins_s        pins,
  input  wire logic [7:0]  data_in
);
  localparam logic [`CNT_W-1:0] STROBE_CYC = `CNT_W'(`STROBE_LOW_CYC);
  localparam logic [`CNT_W-1:0] SETUP_CYC  = `CNT_W'(`SETUP_CYC);
  localparam logic [`CNT_W-1:0] GAP_CYC    = `CNT_W'(`BLW_MIN_CYC);
  localparam logic [`CNT_W-1:0] POLL_CYC   = `CNT_W'(POLL_WAIT_CYCLES);
  localparam logic [`CNT_W-1:0] READ_CYC   = `CNT_W'(`READ_ACCESS_CYC);
  localparam logic [`CNT_W-1:0] REC_CYC    = `CNT_W'(`RECOVER_CYC);
  localparam logic [6:0]        PAGE_MAX   = 7'(`PAGE_BYTES);

  typedef struct packed {
    host_state_e      st;
    logic [`CNT_W-1:0] cnt;
    mem_pins_s        pins;
    logic [10:0]      page;
    logic [16:0]      last_addr;
    logic [7:0]       last_data;
    logic [6:0]       nbytes;
    logic             last;
    logic             done;
    logic             err;
    logic [2:0]       pg_sync;
    logic [3:0]       fill;
    logic [7:0]       rd_q1;
    logic [7:0]       rd_q2;
    logic [7:0]       rd_q3;
  } state_s;

  state_s      s;
  state_s      next_s;
  logic        fifo_valid;
  logic        fifo_take;
  wr_req_s     fifo_req;
  logic [25:0] fifo_bits;
  logic        pg_ok;

  wr_fifo #(
    .WIDTH (26),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_bits)
  );
  assign fifo_req = wr_req_s'(fifo_bits);

  // Power good is asynchronous: act only when the last two stages agree high.
  assign pg_ok      = s.pg_sync[2] && s.pg_sync[1];
  assign pins       = s.pins;
  assign busy       = (s.st != ST_IDLE);
  assign done_pulse = s.done;
  assign page_error = s.err;

  always_comb begin
    next_s         = s;
    next_s.pg_sync = {s.pg_sync[1:0], power_good};
    // Read data comes back from an unclocked memory, so it passes three stages.
    next_s.rd_q1   = data_in;
    next_s.rd_q2   = s.rd_q1;
    next_s.rd_q3   = s.rd_q2;
    next_s.done    = 1'b0;
    fifo_take      = 1'b0;
    if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    case (s.st)
      ST_IDLE: begin
        next_s.pins.cs_n  = 1'b1;
        next_s.pins.og_n  = 1'b1;
        next_s.pins.ws_n  = 1'b1;
        next_s.pins.doe_n = 1'b1;
        next_s.nbytes     = '0;
        if (fifo_valid && pg_ok) begin
          next_s.st        = ST_SETUP;
          next_s.page      = fifo_req.addr[16:6];
          next_s.pins.addr = fifo_req.addr;
          next_s.pins.dout = fifo_req.data;
          next_s.pins.cs_n = 1'b0;
          next_s.pins.doe_n = 1'b0;
          next_s.cnt       = SETUP_CYC;
        end
      end
      ST_SETUP: begin
        if (s.cnt == '0) begin
          // Chip select low, gate high, strobe low: the only write combination.
          next_s.pins.ws_n = 1'b0;
          next_s.cnt       = STROBE_CYC;
          next_s.st        = ST_STROBE;
        end
      end
      ST_STROBE: begin
        // Hold the strobe low until a following byte is queued or this byte ends
        // the page, so a slow source never lets the memory's load window run out.
        if (s.cnt == '0 && fifo_valid &&
            (fifo_req.last || s.nbytes == PAGE_MAX - 7'h01 || s.fill > 4'h1)) begin
          next_s.pins.ws_n = 1'b1;
          next_s.last_addr = s.pins.addr;
          next_s.last_data = s.pins.dout;
          next_s.last      = fifo_req.last;
          next_s.nbytes    = s.nbytes + 1'b1;
          fifo_take        = 1'b1;
          next_s.cnt       = GAP_CYC;
          next_s.st        = ST_GAP;
        end
      end
      ST_GAP: begin
        if (s.last || s.nbytes == PAGE_MAX) begin
          // Stop strobing; the memory's window runs out and writes.
          next_s.pins.cs_n  = 1'b1;
          next_s.pins.doe_n = 1'b1;
          next_s.cnt        = POLL_CYC;
          next_s.st         = ST_WAITLP;
        end else if (s.cnt == '0 && fifo_valid) begin
          next_s.pins.dout = fifo_req.data;
          if (fifo_req.addr[16:6] == s.page) begin
            next_s.pins.addr = fifo_req.addr;
            next_s.pins.cs_n = 1'b0;
            next_s.cnt       = SETUP_CYC;
            next_s.st        = ST_SETUP;
          end else begin
            // A byte outside the page closes this load; it starts the next.
            next_s.err        = 1'b1;
            next_s.pins.cs_n  = 1'b1;
            next_s.pins.doe_n = 1'b1;
            next_s.cnt        = POLL_CYC;
            next_s.st         = ST_WAITLP;
          end
        end
      end
      ST_WAITLP: begin
        if (s.cnt == '0) begin
          next_s.pins.addr = s.last_addr;
          next_s.pins.cs_n = 1'b0;
          next_s.pins.og_n = 1'b0;
          next_s.cnt       = READ_CYC;
          next_s.st        = ST_RD_LOW;
        end
      end
      ST_RD_LOW: begin
        if (s.cnt == '0) begin
          next_s.pins.cs_n = 1'b1;
          next_s.pins.og_n = 1'b1;
          next_s.cnt       = REC_CYC;
          // Trust the read only once the last two stages agree.
          if (s.rd_q3 == s.rd_q2 && s.rd_q2 == s.last_data) begin
            next_s.st = ST_DONE;
          end else begin
            next_s.st = ST_RD_REC;
          end
        end
      end
      ST_RD_REC: begin
        if (s.cnt == '0) begin
          next_s.pins.cs_n = 1'b0;
          next_s.pins.og_n = 1'b0;
          next_s.cnt       = READ_CYC;
          next_s.st        = ST_RD_LOW;
        end
      end
      ST_DONE: begin
        if (s.cnt == '0) begin
          next_s.done = 1'b1;
          next_s.err  = 1'b0;
          next_s.st   = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    // Words held in the queue, tracked so the strobe knows whether a byte follows.
    next_s.fill = s.fill + {3'h0, req_valid && req_ready} - {3'h0, fifo_take};
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s       <= '0;
      s.pins  <= '{addr: 17'h00000, cs_n: 1'b1, og_n: 1'b1, ws_n: 1'b1,
                   dout: 8'h00, doe_n: 1'b1};
      s.st    <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ### include/eeprom_host_regs.svh
// Timing constants for the page-write host controller.
`ifndef EEPROM_HOST_REGS_SVH
`define EEPROM_HOST_REGS_SVH
`define CLK_PERIOD_PS      4000
`define STROBE_LOW_NS      150
`define STROBE_LOW_CYC     ((`STROBE_LOW_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETUP_NS           20
`define SETUP_CYC          ((`SETUP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BLW_MIN_NS         200
`define BLW_MIN_CYC        ((`BLW_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BLW_MAX_US         200
`define POLL_WAIT_MS       1
`define POLL_WAIT_CYC      ((`POLL_WAIT_MS * 1000000000 / `CLK_PERIOD_PS))
`define READ_ACCESS_NS     250
`define READ_ACCESS_CYC    ((`READ_ACCESS_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RECOVER_NS         80
`define RECOVER_CYC        ((`RECOVER_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PAGE_BYTES         64
`define FIFO_DEPTH         8
`define CNT_W              20
`endif

// ### include/eeprom_host_pkg.sv
// Types for the page-write host controller.
package eeprom_host_pkg;
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0]  data;
    logic        last;
  } wr_req_s;

  typedef struct packed {
    logic [16:0] addr;
    logic        cs_n;
    logic        og_n;
    logic        ws_n;
    logic [7:0]  dout;
    logic        doe_n;
  } mem_pins_s;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_SETUP   = 4'b0001,
    ST_STROBE  = 4'b0010,
    ST_GAP     = 4'b0011,
    ST_WAITLP  = 4'b0100,
    ST_RD_LOW  = 4'b0101,
    ST_RD_REC  = 4'b0110,
    ST_DONE    = 4'b0111
  } host_state_e;
endpackage

// ### hw/wr_fifo.sv
// Parameterised FIFO buffering page-write requests.
`timescale 1ns/1ns
module wr_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic             full;
  logic             empty;

  assign empty     = (wp == rp);
  assign full      = (wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp[AW-1:0]];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid && !full) begin
        wp <= wp + 1'b1;
      end
      if (out_ready && !empty) begin
        rp <= rp + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (in_valid && !full) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
endmodule

// ### bench/eeprom_page_host_sva.sv
// Assertion checker for the memory pins of the page-write host.
`timescale 1ns/1ns
`include "eeprom_host_regs.svh"
module eeprom_page_host_sva
  import eeprom_host_pkg::*;
#(
  parameter int POLL_WAIT_CYCLES = 100
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // Request and status
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire wr_req_s    req,
  input wire logic       power_good,
  input wire logic       busy,
  input wire logic       done_pulse,
  input wire logic       page_error,
  // Memory pins
  input wire mem_pins_s  pins,
  input wire logic [7:0] data_in
);
  logic [19:0] low;
  logic [19:0] gap;
  logic [19:0] since;
  logic [7:0]  wd;
  logic        hit;
  logic        polled;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      polled <= 1'h0;
      low   <= '0;
      gap   <= 20'hFFFFF;
      since <= 20'hFFFFF;
      wd    <= '0;
      hit   <= 1'h0;
    end else begin
      polled <= !pins.ws_n ? 1'h0 : (polled | !pins.og_n);
      low   <= pins.ws_n ? 20'h0 : low + 20'h1;
      gap   <= pins.cs_n ? 20'hFFFFF : (!pins.ws_n ? 20'h0 : gap + {19'h0, gap != 20'hFFFFF});
      since <= !pins.ws_n ? 20'h0 : since + {19'h0, since != 20'hFFFFF};
      wd    <= !pins.ws_n ? pins.dout : wd;
      hit   <= !pins.ws_n ? 1'h0 : (hit | (!pins.og_n && data_in == wd));
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  AST_WR_COMBO: assert property (!pins.ws_n |-> !pins.cs_n && pins.og_n)
    else $error("strobe low outside the byte-write combination");
  AST_STROBE_WIDTH: assert property ($rose(pins.ws_n) |-> low >= 20'd38)
    else $error("write strobe low too short");
  AST_COL_HOLD: assert property (!pins.ws_n && $past(!pins.ws_n) |-> $stable(pins.addr))
    else $error("address moved while strobe low");
  AST_DATA_HOLD: assert property ($rose(pins.ws_n) |-> $stable(pins.dout) && !$past(pins.doe_n))
    else $error("data not held through strobe rise");
  AST_PAGE_ADDR: assert property (!pins.cs_n && pins.og_n && $past(!pins.cs_n && pins.og_n)
    |-> $stable(pins.addr[16:6]))
    else $error("bank or row changed within page load");
  AST_BYTE_GAP: assert property ($fell(pins.ws_n) |-> gap >= 20'd50)
    else $error("next byte loaded too soon");
  AST_POLL_WAIT: assert property ($fell(pins.og_n) |-> since >= POLL_WAIT_CYCLES)
    else $error("poll read issued too early");
  AST_POLL_MAX: assert property ($fell(pins.og_n) && !polled |-> since <= `POLL_WAIT_CYC)
    else $error("first poll read issued too late");
  AST_POLL_READ: assert property (!pins.og_n |-> !pins.cs_n && pins.ws_n && pins.doe_n)
    else $error("poll read pins wrong");
  AST_DONE_MATCH: assert property (done_pulse |-> hit ##1 !done_pulse)
    else $error("done without matching poll");
  AST_PWR: assert property ($fell(pins.ws_n) |-> $past(power_good, 3))
    else $error("write started without power good");
  COV_DONE: cover property (done_pulse);
  COV_FULL: cover property (!req_ready);
  COV_POLL: cover property ($fell(pins.og_n));
endmodule
bind eeprom_page_host eeprom_page_host_sva #(.POLL_WAIT_CYCLES(POLL_WAIT_CYCLES)) u_sva (
  .core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .power_good(power_good), .busy(busy), .done_pulse(done_pulse), .page_error(page_error),
  .pins(pins), .data_in(data_in));

// ### bench/eeprom_model.sv
// Behavioural model of the erasable memory behind the host's pins.
`timescale 1ns/1ns
module eeprom_model
  import eeprom_host_pkg::*;
#(
  parameter int LOAD_WINDOW  = 80,
  parameter int WRITE_CYCLES = 300
) (
  // Clock and pins
  input  wire logic      core_clk,
  input  wire mem_pins_s pins,
  // Read data
  output logic [7:0]     data_out
);
  logic [7:0]  mem [logic [16:0]];
  logic [7:0]  last = 8'h00;
  logic [10:0] row = '0;
  logic        prev = 1'h1;
  int          lowc = 0;
  int          win = 0;
  int          left = 0;
  initial data_out = 8'hA5;
  always @(posedge core_clk) begin
    if (left > 0) begin
      left--;
    end else if (pins.ws_n && !prev && !pins.cs_n && pins.og_n && lowc >= 5) begin
      row = (win == 0) ? pins.addr[16:6] : row;
      mem[{row, pins.addr[5:0]}] = pins.dout;
      last = pins.dout;
      win = 1;
    end else if (win > 0) begin
      win = (pins.ws_n && !(pins.ws_n && !pins.cs_n && !prev)) ? win + 1 : 1;
    end
    if (win > LOAD_WINDOW) begin
      win = 0;
      left = WRITE_CYCLES;
    end
    lowc = pins.ws_n ? 0 : lowc + 1;
    prev = pins.ws_n;
    if (!pins.cs_n && !pins.og_n && pins.ws_n) begin
      data_out <= (left > 0 || win > 0) ? ~last : mem[pins.addr];
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule

// ### bench/tb_top.sv
// Self-checking testbench for the page-write host controller.
`timescale 1ns/1ns
module tb_top
  import eeprom_host_pkg::*;
;
  logic       core_clk = 1'h0;
  logic       nrst = 1'h0;
  logic       req_valid = 1'h0;
  logic       power_good = 1'h0;
  wr_req_s    req = '0;
  logic       req_ready;
  logic       busy;
  logic       done_pulse;
  logic       page_error;
  mem_pins_s  pins;
  logic [7:0] data_in;
  int         bad_count = 0;
  int         checked = 0;
  int         cycles = 0;
  always #2 core_clk = ~core_clk;
  eeprom_page_host #(.POLL_WAIT_CYCLES(100)) u_eeprom_page_host (
    .core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .power_good(power_good), .busy(busy), .done_pulse(done_pulse), .page_error(page_error),
    .pins(pins), .data_in(data_in));
  eeprom_model u_eeprom_model (.core_clk(core_clk), .pins(pins), .data_out(data_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic push(input logic [16:0] a, input logic [7:0] d, input logic l);
    logic ok;
    req_valid = 1'h1;
    req = '{addr: a, data: d, last: l};
    do begin
      ok = req_ready;
      @(posedge core_clk);
      #1;
    end while (!ok);
    req_valid = 1'h0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wait_done();
    @(posedge core_clk);
    #1;
    for (int n = 0; n < 3000 && done_pulse !== 1'h1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk(done_pulse, 1'h1, "done");
    chk(busy, 1'h0, "idle at done");
  endtask
  task automatic test_power_hold();
    push(17'h00040, 8'h3C, 1'h1);
    repeat (40) @(posedge core_clk);
    #1;
    chk(pins.cs_n, 1'h1, "cs held off");
    power_good = 1'h1;
    wait_done();
    chk(u_eeprom_model.mem[17'h00040], 8'h3C, "single byte");
    $display("test_power_hold finished");
  endtask
  task automatic test_stretch();
    push(17'h080C1, 8'h5A, 1'h0);
    repeat (300) @(posedge core_clk);
    #1;
    push(17'h080C7, 8'hC3, 1'h1);
    wait_done();
    chk(u_eeprom_model.mem[17'h080C1], 8'h5A, "stretch first");
    chk(u_eeprom_model.mem[17'h080C7], 8'hC3, "stretch second");
    $display("test_stretch finished");
  endtask
  task automatic test_full_page();
    for (int i = 0; i < 64; i++) begin
      push({2'h2, 9'h1A5, 6'(63 - i)}, 8'(i * 3), 1'(i == 63));
      if (i == 7) chk(req_ready, 1'h0, "fifo full");
    end
    wait_done();
    for (int i = 0; i < 64; i++) begin
      chk(u_eeprom_model.mem[{2'h2, 9'h1A5, 6'(63 - i)}], 8'(i * 3), "page byte");
    end
    $display("test_full_page finished");
  endtask
  task automatic test_cross_page();
    push(17'h10005, 8'h11, 1'h0);
    push(17'h10045, 8'h22, 1'h1);
    for (int n = 0; n < 1000 && pins.og_n !== 1'h0; n++) begin
      @(posedge core_clk);
      #1;
    end
    repeat (4) @(posedge core_clk);
    #1;
    chk(data_in, ~8'h11, "poll inverted");
    chk(page_error, 1'h1, "foreign page flagged");
    wait_done();
    chk(page_error, 1'h0, "error cleared at done");
    wait_done();
    chk(u_eeprom_model.mem[17'h10005], 8'h11, "first page byte");
    chk(u_eeprom_model.mem[17'h10045], 8'h22, "next page byte");
    $display("test_cross_page finished");
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      $display("MISMATCH at %0t: timeout", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    nrst = 1'h1;
    test_power_hold();
    test_stretch();
    test_full_page();
    test_cross_page();
    end_of_test();
  end
endmodule
